// ==== logic/ptf_sample_fifo.sv ====
`timescale 1ns/1ps
// Behaviour
// - buffer of 32 entries, 40 bits each
// - enable bit gates buffer, mode field selects
// - threshold flag when count reaches nonzero watermark
// - overrun flag set when occupied entry overwritten
// - six-bit unread count, 32 means full
// - bypass keeps buffer empty, output overwritten
// - writing bypass clears buffer, fifo restarts
// - fifo mode stores until full, then stops
// - depth 32, or watermark plus one
// - fifo mode stops accepting at threshold when threshold interrupt enabled
// - stream mode keeps accepting, drops oldest
// - stream keeps last read entry, count 0 to 2
// - stream overrun overwrites oldest, raises interrupt
// - dynamic stream counts only new samples
// - code 011 fifo when triggered, else stream
// - code 100 stream when triggered, else bypass
// - code 111 fifo when triggered, else bypass
// - read pops oldest, address wraps 2ch to 28h
// - pressure bytes 28h to 2ah, two's complement
// - data ready flags each new output set
// - sub-address auto-increments when increment bit set
module ptf_sample_fifo
    import ptf_pkg::*;
#(
    parameter int DEPTH = PTF_DEPTH,
    parameter int PRESS_W = PTF_PRESS_W,
    parameter int TEMP_W = PTF_TEMP_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // measurement side
    input wire logic sample_valid,
    input wire logic [PRESS_W-1:0] sample_press,
    input wire logic [TEMP_W-1:0] sample_temp,
    input wire logic interrupt_active_flag,
    // register access from the serial front end
    input wire logic reg_start,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // status outputs
    output logic data_ready,
    output logic interrupt_data_ready_pad
);

    localparam int WORD_W = PRESS_W + TEMP_W;
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // resolve mode code and trigger flag into what the buffer does
    function automatic ptf_eff_mode_t resolve_mode(input logic en, input logic [2:0] code, input logic trig);
        ptf_eff_mode_t m;
        m = PTF_EFF_BYPASS;
        if (en) begin
            case (code)
                MODE_BYPASS: m = PTF_EFF_BYPASS;
                MODE_FIFO: m = PTF_EFF_FIFO;
                MODE_STREAM: m = PTF_EFF_STREAM;
                MODE_DYNAMIC_STREAM: m = PTF_EFF_DYNAMIC;
                MODE_STREAM_TO_FIFO: m = trig ? PTF_EFF_FIFO : PTF_EFF_STREAM;
                MODE_BYPASS_TO_STREAM: m = trig ? PTF_EFF_STREAM : PTF_EFF_BYPASS;
                MODE_BYPASS_TO_FIFO: m = trig ? PTF_EFF_FIFO : PTF_EFF_BYPASS;
                default: m = PTF_EFF_BYPASS;
            endcase
        end
        return m;
    endfunction

    // next register address, wrapping inside the output window
    function automatic logic [6:0] advance_addr(input logic [6:0] a);
        logic [6:0] n;
        n = a + 7'h01;
        if (a == ADDR_TEMPERATURE_OUT_HIGH_BYTE) begin
            n = ADDR_PRESSURE_OUT_LOW_BYTE;
        end
        return n;
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [WORD_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic [CNT_W-1:0] count;
    logic kept_entry;
    logic overrun_flag;
    logic [WORD_W-1:0] bypass_word;

    // control registers
    logic [7:0] interrupt_trigger_config;
    logic [7:0] control_two;
    logic [7:0] control_three_irq_route;
    logic [7:0] buffer_control;
    logic [6:0] sub_addr;

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    ptf_eff_mode_t eff_mode;
    logic [2:0] buffer_mode_code;
    logic [4:0] watermark_level;
    logic stop_at_threshold;
    logic addr_increment;
    logic overrun_irq_enable;
    logic threshold_irq_enable;
    logic data_ready_route;
    logic buffer_active;
    logic [CNT_W-1:0] usable_depth;
    logic buffer_full;
    logic threshold_reached_flag;
    logic [5:0] unread_sample_count;

    assign buffer_mode_code = buffer_control[BCTL_MODE_LSB +: 3];
    assign watermark_level = buffer_control[4:0];
    assign stop_at_threshold = control_two[CTL2_STOP_AT_THRESHOLD_BIT];
    assign addr_increment = control_two[CTL2_ADDR_INCREMENT_BIT];
    assign overrun_irq_enable = control_three_irq_route[CTL3_OVERRUN_IRQ_ENABLE_BIT];
    assign threshold_irq_enable = control_three_irq_route[CTL3_THRESHOLD_IRQ_ENABLE_BIT];
    assign data_ready_route = control_three_irq_route[CTL3_DATA_READY_ROUTE_BIT];
    assign eff_mode = resolve_mode(control_two[CTL2_BUFFER_ENABLE_BIT], buffer_mode_code, interrupt_active_flag);
    assign buffer_active = (eff_mode != PTF_EFF_BYPASS);

    // watermark plus one caps the depth when asked to stop there
    assign usable_depth = stop_at_threshold ? (CNT_W'(watermark_level) + CNT_W'(1)) : CNT_W'(DEPTH);
    assign buffer_full = (count >= usable_depth);
    // a zero watermark never reports a threshold
    assign threshold_reached_flag = (watermark_level != 5'h00) && (count >= CNT_W'(watermark_level));
    assign unread_sample_count = 6'(count);

    // ------------------------------------------------------------
    // push and pop decisions
    // ------------------------------------------------------------
    logic reg_read_access;
    logic reg_write_access;
    logic pop_req;
    logic fifo_accept;
    logic do_push;
    logic do_pop;
    logic do_overwrite;

    assign reg_read_access = reg_rd && !reg_start;
    assign reg_write_access = reg_wr && !reg_start;
    // the last byte of the output set marks the whole set as consumed
    assign pop_req = reg_read_access && (sub_addr == ADDR_TEMPERATURE_OUT_HIGH_BYTE);
    assign do_pop = pop_req && buffer_active && (count != '0);

    // fifo mode refuses once full or once the threshold interrupt has fired
    always_comb begin
        fifo_accept = 1'b1;
        case (eff_mode)
            PTF_EFF_FIFO: fifo_accept = !buffer_full
                && !(threshold_irq_enable && threshold_reached_flag);
            PTF_EFF_STREAM: fifo_accept = 1'b1;
            PTF_EFF_DYNAMIC: fifo_accept = 1'b1;
            PTF_EFF_BYPASS: fifo_accept = 1'b0;
            default: fifo_accept = 1'b0;
        endcase
    end

    assign do_push = sample_valid && buffer_active && fifo_accept;
    // a simultaneous pop frees the slot, so nothing is overwritten then
    assign do_overwrite = do_push && buffer_full && !do_pop;

    // ------------------------------------------------------------
    // pointer and count update
    // ------------------------------------------------------------
    logic [PTR_W-1:0] next_rd_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [CNT_W-1:0] next_count;
    logic next_kept_entry;

    always_comb begin
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_count = count;
        next_kept_entry = kept_entry;
        if (do_pop) begin
            if (eff_mode == PTF_EFF_STREAM && count == CNT_W'(1)) begin
                next_kept_entry = 1'b1;
            end else begin
                next_rd_ptr = rd_ptr + PTR_W'(1);
            end
            next_count = count - CNT_W'(1);
        end
        if (do_push) begin
            next_wr_ptr = wr_ptr + PTR_W'(1);
            if (do_overwrite) begin
                next_rd_ptr = next_rd_ptr + PTR_W'(1);
            end else if (next_kept_entry) begin
                // the retained entry is counted again with the new one
                next_count = CNT_W'(2);
                next_kept_entry = 1'b0;
            end else begin
                next_count = next_count + CNT_W'(1);
            end
        end
    end

    // pointers, count and the retained-entry marker; bypass holds them cleared
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
            kept_entry <= 1'b0;
        end else if (clk_en) begin
            if (!buffer_active) begin
                rd_ptr <= '0;
                wr_ptr <= '0;
                count <= '0;
                kept_entry <= 1'b0;
            end else begin
                rd_ptr <= next_rd_ptr;
                wr_ptr <= next_wr_ptr;
                count <= next_count;
                kept_entry <= next_kept_entry;
            end
        end
    end

    // sample storage, no reset so it maps onto plain ram
    always_ff @(posedge clk) begin
        if (clk_en && do_push) begin
            mem[wr_ptr] <= {sample_press, sample_temp};
        end
    end

    // overrun: set wins over the clear from a pop or a flush
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overrun_flag <= 1'b0;
        end else if (clk_en) begin
            if (do_overwrite) begin
                overrun_flag <= 1'b1;
            end else if (do_pop || !buffer_active) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // bypass path: only one location, each sample replaces the last
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bypass_word <= '0;
        end else if (clk_en && sample_valid) begin
            bypass_word <= {sample_press, sample_temp};
        end
    end

    // ------------------------------------------------------------
    // register writes and sub-address pointer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_trigger_config <= RST_INTERRUPT_TRIGGER_CONFIG;
            control_two <= RST_CONTROL_TWO;
            control_three_irq_route <= RST_CONTROL_THREE_IRQ_ROUTE;
            buffer_control <= RST_BUFFER_CONTROL;
        end else if (clk_en && reg_write_access) begin
            case (sub_addr)
                ADDR_INTERRUPT_TRIGGER_CONFIG: interrupt_trigger_config <= reg_wdata;
                ADDR_CONTROL_TWO: control_two <= reg_wdata;
                ADDR_CONTROL_THREE_IRQ_ROUTE: control_three_irq_route <= reg_wdata;
                ADDR_BUFFER_CONTROL: buffer_control <= reg_wdata;
                default: ;
            endcase
        end
    end

    // start loads the address; each byte access then steps it if enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sub_addr <= '0;
        end else if (clk_en) begin
            if (reg_start) begin
                sub_addr <= reg_addr;
            end else if ((reg_read_access || reg_write_access) && addr_increment) begin
                sub_addr <= advance_addr(sub_addr);
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [WORD_W-1:0] head_word;
    logic [PRESS_W-1:0] head_press;
    logic [TEMP_W-1:0] head_temp;
    logic [7:0] read_mux;

    // oldest stored entry while buffering, latest sample otherwise
    assign head_word = buffer_active ? mem[rd_ptr] : bypass_word;
    assign head_press = head_word[WORD_W-1 -: PRESS_W];
    assign head_temp = head_word[TEMP_W-1:0];

    always_comb begin
        read_mux = 8'h00;
        case (sub_addr)
            ADDR_INTERRUPT_TRIGGER_CONFIG: read_mux = interrupt_trigger_config;
            ADDR_CONTROL_TWO: read_mux = control_two;
            ADDR_CONTROL_THREE_IRQ_ROUTE: read_mux = control_three_irq_route;
            ADDR_BUFFER_CONTROL: read_mux = buffer_control;
            ADDR_BUFFER_STATUS: read_mux = {threshold_reached_flag, overrun_flag, unread_sample_count};
            ADDR_PRESSURE_OUT_LOW_BYTE: read_mux = head_press[7:0];
            ADDR_PRESSURE_OUT_MID_BYTE: read_mux = head_press[15:8];
            ADDR_PRESSURE_OUT_HIGH_BYTE: read_mux = head_press[23:16];
            ADDR_TEMPERATURE_OUT_LOW_BYTE: read_mux = head_temp[7:0];
            ADDR_TEMPERATURE_OUT_HIGH_BYTE: read_mux = head_temp[15:8];
            default: read_mux = 8'h00;
        endcase
    end

    // read byte is held until the next read access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_read_access) begin
            reg_rdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // data ready and interrupt pad
    // ------------------------------------------------------------
    // a new set beats the clear from reading the last output byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_ready <= 1'b0;
        end else if (clk_en) begin
            if (sample_valid) begin
                data_ready <= 1'b1;
            end else if (pop_req) begin
                data_ready <= 1'b0;
            end
        end
    end

    // pad ors the routed sources; registered so the pin never glitches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_data_ready_pad <= 1'b0;
        end else if (clk_en) begin
            interrupt_data_ready_pad <= (data_ready_route && data_ready)
                || (overrun_irq_enable && overrun_flag)
                || (threshold_irq_enable && threshold_reached_flag);
        end
    end

endmodule

// ==== common/ptf_pkg.sv ====
package ptf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_INTERRUPT_TRIGGER_CONFIG = 7'h0b;
    localparam logic [6:0] ADDR_CONTROL_TWO = 7'h11;
    localparam logic [6:0] ADDR_CONTROL_THREE_IRQ_ROUTE = 7'h12;
    localparam logic [6:0] ADDR_BUFFER_CONTROL = 7'h14;
    localparam logic [6:0] ADDR_BUFFER_STATUS = 7'h26;
    localparam logic [6:0] ADDR_PRESSURE_OUT_LOW_BYTE = 7'h28;
    localparam logic [6:0] ADDR_PRESSURE_OUT_MID_BYTE = 7'h29;
    localparam logic [6:0] ADDR_PRESSURE_OUT_HIGH_BYTE = 7'h2a;
    localparam logic [6:0] ADDR_TEMPERATURE_OUT_LOW_BYTE = 7'h2b;
    localparam logic [6:0] ADDR_TEMPERATURE_OUT_HIGH_BYTE = 7'h2c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL2_BUFFER_ENABLE_BIT = 6;
    localparam int CTL2_STOP_AT_THRESHOLD_BIT = 5;
    localparam int CTL2_ADDR_INCREMENT_BIT = 4;
    localparam int CTL3_THRESHOLD_IRQ_ENABLE_BIT = 4;
    localparam int CTL3_OVERRUN_IRQ_ENABLE_BIT = 3;
    localparam int CTL3_DATA_READY_ROUTE_BIT = 2;
    localparam int BCTL_MODE_LSB = 5;
    localparam int STAT_THRESHOLD_BIT = 7;
    localparam int STAT_OVERRUN_BIT = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_INTERRUPT_TRIGGER_CONFIG = 8'h00;
    localparam logic [7:0] RST_CONTROL_TWO = 8'h10;
    localparam logic [7:0] RST_CONTROL_THREE_IRQ_ROUTE = 8'h00;
    localparam logic [7:0] RST_BUFFER_CONTROL = 8'h00;

    // ------------------------------------------------------------
    // buffer sizing and mode codes
    // ------------------------------------------------------------
    localparam int PTF_DEPTH = 32;
    localparam int PTF_PRESS_W = 24;
    localparam int PTF_TEMP_W = 16;
    localparam logic [2:0] MODE_BYPASS = 3'h0;
    localparam logic [2:0] MODE_FIFO = 3'h1;
    localparam logic [2:0] MODE_STREAM = 3'h2;
    localparam logic [2:0] MODE_STREAM_TO_FIFO = 3'h3;
    localparam logic [2:0] MODE_BYPASS_TO_STREAM = 3'h4;
    localparam logic [2:0] MODE_DYNAMIC_STREAM = 3'h6;
    localparam logic [2:0] MODE_BYPASS_TO_FIFO = 3'h7;

    // effective behaviour after trigger resolution, gray along bypass-fifo-stream-dynamic
    typedef enum logic [1:0] {
        PTF_EFF_BYPASS = 2'b00,
        PTF_EFF_FIFO = 2'b01,
        PTF_EFF_STREAM = 2'b11,
        PTF_EFF_DYNAMIC = 2'b10
    } ptf_eff_mode_t;

endpackage

// ==== testbench/ptf_meas_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// measurement chain stand-in
// ------------------------------------------------------------
module ptf_meas_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [7:0] burst,
    input wire logic slow,
    output logic sample_valid,
    output logic [23:0] sample_press,
    output logic [15:0] sample_temp,
    output logic busy
);
    logic [7:0] left;
    logic [7:0] idx;
    logic [1:0] gap;
    assign busy = left != 8'h00;
    // one set per tick; data lines toggle between sets so stale values never pass as valid
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left <= 8'h00;
            idx <= 8'h00;
            gap <= 2'h0;
            sample_valid <= 1'b0;
            sample_press <= 24'h000000;
            sample_temp <= 16'h0000;
        end else begin
            sample_valid <= 1'b0;
            sample_press <= ~sample_press;
            sample_temp <= ~sample_temp;
            if (go) begin
                left <= burst;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end else if (busy) begin
                sample_valid <= 1'b1;
                sample_press <= {8'hc0, ~idx, idx};
                sample_temp <= {~idx, idx ^ 8'h3c};
                idx <= idx + 8'h01;
                left <= left - 8'h01;
                gap <= slow ? 2'h2 : 2'h0;  // slow ticks leave idle cycles between sets
            end
        end
    end
endmodule

// ==== testbench/ptf_sample_fifo_sva.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module ptf_sample_fifo_chk #(
    parameter int PRESS_W = 24,
    parameter int TEMP_W = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sample_valid,
    input wire logic [PRESS_W-1:0] sample_press,
    input wire logic [TEMP_W-1:0] sample_temp,
    input wire logic interrupt_active_flag,
    input wire logic reg_start,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic data_ready,
    input wire logic interrupt_data_ready_pad
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // outputs quiet on the first edge after release
    a_reset_quiet: assert property ($rose(arst_n) |-> reg_rdata == 8'h00 && !data_ready && !interrupt_data_ready_pad) else $error("outputs not quiet after reset");
    a_ready_on_sample: assert property (sample_valid && clk_en |=> data_ready) else $error("data ready missed a sample");
    a_ready_holds: assert property (data_ready && !(clk_en && reg_rd) |=> data_ready) else $error("data ready dropped without read");
    a_ready_drop: assert property ($fell(data_ready) |-> $past(clk_en && reg_rd)) else $error("data ready fell without read");
    a_ready_cause: assert property ($rose(data_ready) |-> $past(clk_en && sample_valid)) else $error("data ready rose without sample");
    a_rdata_cause: assert property ($changed(reg_rdata) |-> $past(clk_en && reg_rd && !reg_start)) else $error("read data moved without read");
    a_freeze_all: assert property (!clk_en |=> $stable(reg_rdata) && $stable(data_ready) && $stable(interrupt_data_ready_pad)) else $error("state moved while frozen");
    a_unmapped_zero: assert property (clk_en && reg_start && reg_addr == 7'h00 ##1 clk_en && reg_rd && !reg_start |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

bind ptf_sample_fifo ptf_sample_fifo_chk #(.PRESS_W(PRESS_W), .TEMP_W(TEMP_W)) chk_i (.clk(clk), .arst_n(arst_n),
    .clk_en(clk_en), .sample_valid(sample_valid), .sample_press(sample_press), .sample_temp(sample_temp),
    .interrupt_active_flag(interrupt_active_flag), .reg_start(reg_start), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_ready(data_ready),
    .interrupt_data_ready_pad(interrupt_data_ready_pad));

// ==== testbench/test_pressure_temp_sample_fifo.sv ====
`timescale 1ns/1ps
module test_pressure_temp_sample_fifo;
    import ptf_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, interrupt_active_flag = 1'b0;
    logic sample_valid, busy, data_ready, pad, go = 1'b0, slow = 1'b0;
    logic [23:0] sample_press;
    logic [15:0] sample_temp;
    logic reg_start = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, burst = 8'h00;
    logic [7:0] rb [0:7];
    int failures = 0, comparisons = 0, seq = 0, s;
    always #2 clk = ~clk;
    ptf_sample_fifo ptf_sample_fifo_i (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .sample_valid(sample_valid),
        .sample_press(sample_press), .sample_temp(sample_temp), .interrupt_active_flag(interrupt_active_flag),
        .reg_start(reg_start), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .data_ready(data_ready), .interrupt_data_ready_pad(pad));
    ptf_meas_model ptf_meas_model_i (.clk(clk), .arst_n(arst_n), .go(go), .burst(burst), .slow(slow),
        .sample_valid(sample_valid), .sample_press(sample_press), .sample_temp(sample_temp), .busy(busy));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk) reg_start <= 1'b1;
        reg_addr <= a;
        @(posedge clk) reg_start <= 1'b0;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    // burst read from one start; byte i lands a cycle after its read pulse
    task automatic rd(input logic [6:0] a, input int n);
        @(posedge clk) reg_start <= 1'b1;
        reg_addr <= a;
        @(posedge clk) reg_start <= 1'b0;
        reg_rd <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i == n - 1) reg_rd <= 1'b0;
            #1 rb[i] = reg_rdata;
        end
    endtask
    task automatic stat(input logic [7:0] e);
        rd(ADDR_BUFFER_STATUS, 1);
        chk("status", rb[0], e);
    endtask
    task automatic push(input int n);
        int k;
        k = 0;
        @(posedge clk) go <= 1'b1;
        burst <= n[7:0];
        @(posedge clk) go <= 1'b0;
        #1;
        while (busy && k < 1000) begin
            @(posedge clk);
            #1 k++;
        end
        repeat (2) @(posedge clk);
        seq += n;
    endtask
    // bytes 28h..2ch of set n: pressure low, mid, high, then temperature low, high
    task automatic chk_entry(input int n);
        logic [7:0] i8;
        logic [7:0] b [0:4];
        i8 = n[7:0];
        b = '{i8, ~i8, 8'hc0, i8 ^ 8'h3c, ~i8};
        for (int i = 0; i < 5; i++) chk("out_byte", rb[i], b[i]);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [6:0] a [0:5] = '{7'h0b, 7'h11, 7'h12, 7'h14, 7'h26, 7'h00};
        logic [7:0] e [0:5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(a[i], 1);
            chk("reset_value", rb[0], e[i]);
        end
        wr(ADDR_BUFFER_STATUS, 8'hff);
        stat(8'h00);
        wr(ADDR_INTERRUPT_TRIGGER_CONFIG, 8'ha5);
        rd(ADDR_INTERRUPT_TRIGGER_CONFIG, 1);
        chk("trigger_config", rb[0], 8'ha5);
    endtask
    task automatic t_fill;
        wr(ADDR_CONTROL_TWO, 8'h50);
        wr(ADDR_BUFFER_CONTROL, 8'h20);
        s = seq;
        push(33);
        stat(8'h20);
        rd(ADDR_PRESSURE_OUT_LOW_BYTE, 6);
        chk_entry(s);
        chk("wrap_byte", rb[5], s[7:0] + 8'h01);
        stat(8'h1f);
        chk("ready_clear", {7'h0, data_ready}, 8'h00);
    endtask
    task automatic t_threshold;
        wr(ADDR_BUFFER_CONTROL, 8'h00);
        stat(8'h00);
        wr(ADDR_BUFFER_CONTROL, 8'h24);
        push(3);
        stat(8'h03);
        push(1);
        stat(8'h84);
        wr(ADDR_CONTROL_TWO, 8'h70);
        push(5);
        stat(8'h85);
        wr(ADDR_BUFFER_CONTROL, 8'h00);
        wr(ADDR_CONTROL_TWO, 8'h50);
        wr(ADDR_CONTROL_THREE_IRQ_ROUTE, 8'h10);
        wr(ADDR_BUFFER_CONTROL, 8'h24);
        push(6);
        stat(8'h84);
        wr(ADDR_CONTROL_THREE_IRQ_ROUTE, 8'h00);
    endtask
    task automatic t_stream;
        wr(ADDR_BUFFER_CONTROL, 8'h00);
        wr(ADDR_BUFFER_CONTROL, 8'h40);
        s = seq;
        push(34);
        stat(8'h60);
        rd(ADDR_PRESSURE_OUT_LOW_BYTE, 5);
        chk_entry(s + 2);
        repeat (31) rd(ADDR_PRESSURE_OUT_LOW_BYTE, 5);
        stat(8'h00);
        slow <= 1'b1;
        push(1);
        slow <= 1'b0;
        stat(8'h02);
        rd(ADDR_PRESSURE_OUT_LOW_BYTE, 5);
        chk_entry(s + 33);
    endtask
    task automatic t_dynamic;
        wr(ADDR_BUFFER_CONTROL, 8'h00);
        wr(ADDR_BUFFER_CONTROL, 8'hc0);
        s = seq;
        push(3);
        repeat (3) rd(ADDR_PRESSURE_OUT_LOW_BYTE, 5);
        stat(8'h00);
        push(1);
        stat(8'h01);
        rd(ADDR_PRESSURE_OUT_LOW_BYTE, 5);
        chk_entry(s + 3);
    endtask
    task automatic t_modes;
        logic [7:0] m [0:5] = '{8'h80, 8'h80, 8'he0, 8'he0, 8'h60, 8'h60};
        logic f [0:5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [7:0] e [0:5] = '{8'h00, 8'h02, 8'h00, 8'h02, 8'h02, 8'h02};
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_BUFFER_CONTROL, 8'h00);
            interrupt_active_flag <= f[i];
            wr(ADDR_BUFFER_CONTROL, m[i]);
            push(2);
            stat(e[i]);
        end
        interrupt_active_flag <= 1'b0;
        wr(ADDR_BUFFER_CONTROL, 8'h00);
        push(1);
        stat(8'h00);
        rd(ADDR_PRESSURE_OUT_LOW_BYTE, 5);
        chk_entry(seq - 1);
        wr(ADDR_CONTROL_TWO, 8'h10);
        wr(ADDR_BUFFER_CONTROL, 8'h20);
        push(1);
        stat(8'h00);
    endtask
    task automatic t_pad_freeze;
        wr(ADDR_CONTROL_TWO, 8'h50);
        wr(ADDR_BUFFER_CONTROL, 8'h00);
        wr(ADDR_BUFFER_CONTROL, 8'h20);
        wr(ADDR_CONTROL_THREE_IRQ_ROUTE, 8'h04);
        push(1);
        #1;
        chk("pad", {7'h0, pad}, 8'h01);
        chk("ready", {7'h0, data_ready}, 8'h01);
        @(posedge clk) clk_en <= 1'b0;
        push(1);
        @(posedge clk) clk_en <= 1'b1;
        stat(8'h01);
        wr(ADDR_CONTROL_TWO, 8'h40);
        rd(ADDR_PRESSURE_OUT_LOW_BYTE, 2);
        chk("no_step_0", rb[0], s[7:0]);
        chk("no_step_1", rb[1], s[7:0]);
        wr(ADDR_CONTROL_THREE_IRQ_ROUTE, 8'h00);
    endtask
    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic close_out;
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_fill();
        t_threshold();
        t_stream();
        t_dynamic();
        t_modes();
        s = seq;
        t_pad_freeze();
        close_out();
    end
    // generous bound: the sequence needs well under ten thousand cycles
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule
